// ### hw/sacm_pkg.sv
/*
 * Package for the servo alarm code manager: alarm codes, fault bit indices,
 * register-port offsets and field layouts.
 * Assumes a single 100 MHz clock domain and a synchronous active-high reset.
 */
package sacm_pkg;

  localparam int NUM_FAULTS = 40;

  // Fault input bit positions (per axis fault vector)
  localparam int F_PHASE_DISC  = 0;
  localparam int F_COMM_DISC   = 1;
  localparam int F_OVERLOAD    = 2;
  localparam int F_AD_CHAN     = 3;
  localparam int F_COMM_ILLEG  = 4;
  localparam int F_COMM_ORDER  = 5;
  localparam int F_OVERCURR    = 6;
  localparam int F_OVERVOLT    = 7;
  localparam int F_UNDERVOLT   = 8;
  localparam int F_PARAM_BAD   = 9;
  localparam int F_OVERSPEED   = 10;
  localparam int F_DEV_OVF     = 11;
  localparam int F_DEV_LIMIT   = 12;
  localparam int F_GEAR        = 13;
  localparam int F_CUR_DET1    = 14;
  localparam int F_CUR_DET2    = 15;
  localparam int F_MOTOR_MODEL = 16;
  localparam int F_MISMATCH    = 17;
  localparam int F_MT_ERR      = 18;
  localparam int F_MT_OVF      = 19;
  localparam int F_BATT_LOST   = 20;
  localparam int F_BATT_LOW    = 21;
  localparam int F_BLEEDER     = 22;
  localparam int F_REGEN       = 23;
  localparam int F_OUTAGE      = 24;
  localparam int F_RESOLVER    = 25;
  localparam int F_ENC_COMM    = 26;
  localparam int F_ENC_OVSPD   = 27;
  localparam int F_ENC_ABS     = 28;
  localparam int F_ENC_COUNT   = 29;
  localparam int F_CTRL_CHK    = 30;
  localparam int F_DATA_CHK    = 31;
  localparam int F_STAT_STOP   = 32;
  localparam int F_MEM_STOP    = 33;
  localparam int F_MEM_NULL    = 34;
  localparam int F_MEM_SUM     = 35;
  localparam int F_MODBUS_TO   = 36;
  localparam int F_HBEAT_TO    = 37;
  localparam int F_OVERHEAT    = 38;
  localparam int F_SW_HW       = 39;

  // Two-digit alarm codes as BCD, indexed by fault bit
  localparam logic [7:0] ALARM_CODE [NUM_FAULTS] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h10, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h22, 8'h23, 8'h25, 8'h26,
    8'h27, 8'h28, 8'h30, 8'h31, 8'h33, 8'h34, 8'h40, 8'h41, 8'h42, 8'h43,
    8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h60, 8'h61, 8'h70, 8'h90
  };

  // Faults that a clear request can never remove
  localparam logic [NUM_FAULTS-1:0] NO_CLEAR_MASK =
    (40'h1 << F_OVERVOLT) | (40'h1 << F_UNDERVOLT) |
    (40'h1 << F_REGEN) | (40'h1 << F_SW_HW);

  // Faults that need the encoder's own alarm cleared first
  localparam logic [NUM_FAULTS-1:0] ENC_GATE_MASK =
    (40'h1 << F_MT_ERR) | (40'h1 << F_MT_OVF) |
    (40'h1 << F_BATT_LOST) | (40'h1 << F_ENC_OVSPD);

  // Axis prefix letters in ASCII
  localparam logic [7:0] AXIS_A_CHAR = 8'h41;
  localparam logic [7:0] AXIS_B_CHAR = 8'h62;

  localparam logic [7:0] NO_ALARM_CODE = 8'h00;

  // Register port
  localparam int          ADDR_W       = 4;
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h1;
  localparam logic [3:0]  REG_LATCH_A0 = 4'h2;
  localparam logic [3:0]  REG_LATCH_A1 = 4'h3;
  localparam logic [3:0]  REG_LATCH_B0 = 4'h4;
  localparam logic [3:0]  REG_LATCH_B1 = 4'h5;
  localparam logic [3:0]  REG_DEV_LIM  = 4'h6;
  localparam logic [3:0]  REG_DEV_A    = 4'h7;
  localparam logic [3:0]  REG_DEV_B    = 4'h8;

  // Control register fields
  localparam int CTRL_CLR_A     = 0;
  localparam int CTRL_CLR_B     = 1;
  localparam int CTRL_ENC_ACK_A = 2;
  localparam int CTRL_ENC_ACK_B = 3;

  localparam logic [31:0] DEV_LIM_RST = 32'h0000FFFF;

endpackage

// ### hw/sacm_top.sv
/*
 * Servo alarm code manager for a two-axis drive: latches faults per axis,
 * shows the first alarm with its axis letter, drives the fault output and
 * the coast-stop commands, and gates clear requests.
 * Assumes fault detectors on clk; pin inputs are synchronised here.
 */
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps

// Function
// R1: Any active alarm removes drive without braking so the motor coasts.
// R2: Fault output high while any alarm is latched, low otherwise.
// R3: Alarm 01 for phase lines open, 02 for commutation lines open; clearable.
// R4: Alarm 05 for illegal commutation code, 06 for wrong phase order.
// R5: Alarms 03 overload, 10 overcurrent, 14 overspeed; all clearable.
// R6: Alarms 11, 12, 31, 90 never clear; all others clear on request.
// R7: Alarm 13 when stored parameters are corrupted.
// R8: Alarm 15 on deviation counter overflow, 16 when deviation exceeds limit.
// R9: Alarm 17 for bad gear ratio or command pulse rate too high.
// R10: Alarm 25 multi-turn error, 26 multi-turn overflow from encoder.
// R11: Alarm 27 battery below 2.5 V with data lost; 28 below 3.1 V.
// R12: Alarm 33 when AC supply drops for over one mains cycle.
// R13: Alarm 40 when the serial encoder stops communicating.
// R14: Alarm 42 encoder absolute status error, 43 counting error.
// R15: Alarm 44 control field check fails, 45 data check fails.
// R16: Alarm 46 status field stop bit wrong, 47 memory field stop bit wrong.
// R17: Alarm 48 when encoder memory field reads back null.
// R18: Alarm 49 when encoder memory sum check fails.
// R19: Host must send frames within timeout, else alarm 60.
// R20: Master heartbeat missing in time raises alarm 61.
// R21: Displayed code carries axis letter, A first axis, b second.
// R22: Alarms 25, 26, 27, 41 clear only after encoder alarm is cleared.
// R23: Host clear via communication register only when no pin is assigned.
// R24: Alarm stays latched until valid clear and fault gone.
// R25: First detected alarm is displayed while output stays high.
module sacm_top
  import sacm_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Fault detectors, one vector per axis
  input  wire logic [NUM_FAULTS-1:0] fault_a,
  input  wire logic [NUM_FAULTS-1:0] fault_b,
  // Deviation magnitudes per axis
  input  wire logic [31:0]           deviation_a,
  input  wire logic [31:0]           deviation_b,
  // Alarm clear pin (active low) and its assignment
  input  wire logic                  fault_clear_input_n,
  input  wire logic                  clear_pin_assigned,
  // Register port
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // Alarm outputs
  output logic                       fault_output,
  output logic                       coast_a,
  output logic                       coast_b,
  output logic      [7:0]            disp_axis,
  output logic      [7:0]            disp_code
);

  logic [NUM_FAULTS-1:0] latch_a_ff;
  logic [NUM_FAULTS-1:0] latch_b_ff;
  logic [NUM_FAULTS-1:0] enc_ok_a_ff;
  logic [NUM_FAULTS-1:0] enc_ok_b_ff;
  logic [31:0]           dev_lim_ff;
  logic [7:0]            first_axis_ff;
  logic [7:0]            first_code_ff;
  logic                  first_valid_ff;
  logic                  clr_pin_s1_ff;
  logic                  clr_pin_s2_ff;
  logic                  clr_pin_d_ff;
  logic [31:0]           rdata_ff;

  // Code of lowest set bit, used to pick one code per axis
  function automatic logic [7:0] first_code(input logic [NUM_FAULTS-1:0] v);
    logic [7:0] c;
    c = NO_ALARM_CODE;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        c = ALARM_CODE[i];
      end
    end
    return c;
  endfunction

  // Deviation limit check folded into the fault vector
  wire dev_over_a = deviation_a > dev_lim_ff;
  wire dev_over_b = deviation_b > dev_lim_ff;
  wire [NUM_FAULTS-1:0] src_a = fault_a | (dev_over_a ? (40'h1 << F_DEV_LIMIT) : '0); // R8
  wire [NUM_FAULTS-1:0] src_b = fault_b | (dev_over_b ? (40'h1 << F_DEV_LIMIT) : '0); // R8

  // Clear requests: pin falling edge when assigned, else register bit
  wire ctrl_wr    = reg_wr && (reg_addr == REG_CTRL);
  wire pin_clr    = clear_pin_assigned && clr_pin_d_ff && !clr_pin_s2_ff;
  wire reg_clr_a  = ctrl_wr && reg_wdata[CTRL_CLR_A] && !clear_pin_assigned; // R23
  wire reg_clr_b  = ctrl_wr && reg_wdata[CTRL_CLR_B] && !clear_pin_assigned; // R23
  wire clr_a      = pin_clr || reg_clr_a;
  wire clr_b      = pin_clr || reg_clr_b;
  wire enc_ack_a  = ctrl_wr && reg_wdata[CTRL_ENC_ACK_A];
  wire enc_ack_b  = ctrl_wr && reg_wdata[CTRL_ENC_ACK_B];

  // A bit clears only if clearable, gated bits acknowledged, and fault gone
  wire [NUM_FAULTS-1:0] clrable_a = ~NO_CLEAR_MASK & (~ENC_GATE_MASK | enc_ok_a_ff); // R6 R22
  wire [NUM_FAULTS-1:0] clrable_b = ~NO_CLEAR_MASK & (~ENC_GATE_MASK | enc_ok_b_ff); // R6 R22
  wire [NUM_FAULTS-1:0] drop_a = clr_a ? (clrable_a & ~src_a) : '0; // R24
  wire [NUM_FAULTS-1:0] drop_b = clr_b ? (clrable_b & ~src_b) : '0; // R24
  // Set wins over clear
  wire [NUM_FAULTS-1:0] nxt_latch_a = (latch_a_ff & ~drop_a) | src_a; // R3 R4 R5 R7 R9 R10
  wire [NUM_FAULTS-1:0] nxt_latch_b = (latch_b_ff & ~drop_b) | src_b; // R11 R12 R13 R14 R15

  wire any_a = |latch_a_ff;
  wire any_b = |latch_b_ff;

  // Capture first alarm; hold until all alarms gone
  wire new_a = |nxt_latch_a;
  wire new_b = |nxt_latch_b;
  wire       nxt_first_valid = new_a || new_b;
  wire [7:0] nxt_first_axis  = first_valid_ff ? first_axis_ff :
                               (new_a ? AXIS_A_CHAR : AXIS_B_CHAR); // R21
  wire [7:0] nxt_first_code  = first_valid_ff ? first_code_ff :
                               (new_a ? first_code(nxt_latch_a) : first_code(nxt_latch_b)); // R25

  // Register read decode
  wire [31:0] nxt_rdata =
    (reg_addr == REG_CTRL)     ? {28'h0, enc_ok_b_ff[F_MT_ERR], enc_ok_a_ff[F_MT_ERR], 2'h0} :
    (reg_addr == REG_STATUS)   ? {8'h0, first_axis_ff, first_code_ff, 5'h0,
                                  first_valid_ff, any_b, any_a} :
    (reg_addr == REG_LATCH_A0) ? latch_a_ff[31:0] :
    (reg_addr == REG_LATCH_A1) ? {24'h0, latch_a_ff[NUM_FAULTS-1:32]} :
    (reg_addr == REG_LATCH_B0) ? latch_b_ff[31:0] :
    (reg_addr == REG_LATCH_B1) ? {24'h0, latch_b_ff[NUM_FAULTS-1:32]} :
    (reg_addr == REG_DEV_LIM)  ? dev_lim_ff :
    (reg_addr == REG_DEV_A)    ? deviation_a :
    (reg_addr == REG_DEV_B)    ? deviation_b : 32'h0;

  // Encoder-alarm acknowledge: set by software, consumed by a clear
  wire [NUM_FAULTS-1:0] nxt_enc_ok_a = enc_ack_a ? ENC_GATE_MASK :
                                       (clr_a ? '0 : enc_ok_a_ff); // R22
  wire [NUM_FAULTS-1:0] nxt_enc_ok_b = enc_ack_b ? ENC_GATE_MASK :
                                       (clr_b ? '0 : enc_ok_b_ff); // R22

  always_ff @(posedge clk) begin
    if (srst) begin
      latch_a_ff     <= '0;
      latch_b_ff     <= '0;
      enc_ok_a_ff    <= '0;
      enc_ok_b_ff    <= '0;
      dev_lim_ff     <= DEV_LIM_RST;
      first_valid_ff <= 1'b0;
      first_axis_ff  <= NO_ALARM_CODE;
      first_code_ff  <= NO_ALARM_CODE;
      rdata_ff       <= '0;
    end else begin
      latch_a_ff     <= nxt_latch_a;
      latch_b_ff     <= nxt_latch_b;
      enc_ok_a_ff    <= nxt_enc_ok_a;
      enc_ok_b_ff    <= nxt_enc_ok_b;
      if (reg_wr && reg_addr == REG_DEV_LIM) begin
        dev_lim_ff   <= reg_wdata;
      end
      first_valid_ff <= nxt_first_valid;
      first_axis_ff  <= nxt_first_valid ? nxt_first_axis : NO_ALARM_CODE;
      first_code_ff  <= nxt_first_valid ? nxt_first_code : NO_ALARM_CODE;
      rdata_ff       <= reg_rd ? nxt_rdata : 32'h0;
    end
  end

  // Clear pin synchroniser and edge history
  always_ff @(posedge clk) begin
    if (srst) begin
      clr_pin_s1_ff <= 1'b1;
      clr_pin_s2_ff <= 1'b1;
      clr_pin_d_ff  <= 1'b1;
    end else begin
      clr_pin_s1_ff <= fault_clear_input_n;
      clr_pin_s2_ff <= clr_pin_s1_ff;
      clr_pin_d_ff  <= clr_pin_s2_ff;
    end
  end

  assign reg_rdata    = rdata_ff;
  assign fault_output = first_valid_ff; // R2
  assign coast_a      = any_a;          // R1
  assign coast_b      = any_b;          // R1
  assign disp_axis    = first_axis_ff;  // R21
  assign disp_code    = first_code_ff;  // R25

  // Assertions
  a_out_tracks_latch: assert property (@(posedge clk) disable iff (srst) // R2
    fault_output == (any_a || any_b)) else $error("fault output disagrees with latches");

  a_coast_on_alarm: assert property (@(posedge clk) disable iff (srst) // R1
    (any_a |-> coast_a) and (any_b |-> coast_b)) else $error("no coast stop on alarm");

  a_set_latches: assert property (@(posedge clk) disable iff (srst) // R3
    fault_a[F_PHASE_DISC] |=> latch_a_ff[F_PHASE_DISC]) else $error("alarm 01 not latched");

  a_noclear_holds: assert property (@(posedge clk) disable iff (srst) // R6
    latch_a_ff[F_OVERVOLT] |=> latch_a_ff[F_OVERVOLT]) else $error("alarm 11 was cleared");

  a_gate_holds: assert property (@(posedge clk) disable iff (srst) // R22
    latch_b_ff[F_MT_ERR] && !enc_ok_b_ff[F_MT_ERR] |=> latch_b_ff[F_MT_ERR])
    else $error("alarm 25 cleared without encoder acknowledge");

  a_hold_no_clear: assert property (@(posedge clk) disable iff (srst) // R24
    latch_a_ff[F_OVERSPEED] && !clr_a |=> latch_a_ff[F_OVERSPEED])
    else $error("alarm dropped without clear");

  a_dev_limit: assert property (@(posedge clk) disable iff (srst) // R8
    deviation_a > dev_lim_ff |=> latch_a_ff[F_DEV_LIMIT]) else $error("alarm 16 missed");

  a_first_stable: assert property (@(posedge clk) disable iff (srst) // R25
    first_valid_ff && $past(first_valid_ff) |-> $stable(disp_code))
    else $error("displayed alarm changed while active");

  a_axis_letter: assert property (@(posedge clk) disable iff (srst) // R21
    first_valid_ff |-> (disp_axis == AXIS_A_CHAR || disp_axis == AXIS_B_CHAR))
    else $error("bad axis letter");

  a_pin_blocks_reg: assert property (@(posedge clk) disable iff (srst) // R23
    clear_pin_assigned |-> !reg_clr_a) else $error("register clear while pin assigned");

  // Detected faults of R3 to R20 (R6 aside) on axis A latch on the next edge
  a_set_a02: assert property (@(posedge clk) disable iff (srst) // R3
    fault_a[F_COMM_DISC] |=> latch_a_ff[F_COMM_DISC]) else $error("A02 not latched");

  a_set_a05: assert property (@(posedge clk) disable iff (srst) // R4
    fault_a[F_COMM_ILLEG] |=> latch_a_ff[F_COMM_ILLEG]) else $error("A05 not latched");

  a_set_a06: assert property (@(posedge clk) disable iff (srst) // R4
    fault_a[F_COMM_ORDER] |=> latch_a_ff[F_COMM_ORDER]) else $error("A06 not latched");

  a_set_a03: assert property (@(posedge clk) disable iff (srst) // R5
    fault_a[F_OVERLOAD] |=> latch_a_ff[F_OVERLOAD]) else $error("A03 not latched");

  a_set_a10: assert property (@(posedge clk) disable iff (srst) // R5
    fault_a[F_OVERCURR] |=> latch_a_ff[F_OVERCURR]) else $error("A10 not latched");

  a_set_a14: assert property (@(posedge clk) disable iff (srst) // R5
    fault_a[F_OVERSPEED] |=> latch_a_ff[F_OVERSPEED]) else $error("A14 not latched");

  a_set_a13: assert property (@(posedge clk) disable iff (srst) // R7
    fault_a[F_PARAM_BAD] |=> latch_a_ff[F_PARAM_BAD]) else $error("A13 not latched");

  a_set_a15: assert property (@(posedge clk) disable iff (srst) // R8
    fault_a[F_DEV_OVF] |=> latch_a_ff[F_DEV_OVF]) else $error("A15 not latched");

  a_set_a17: assert property (@(posedge clk) disable iff (srst) // R9
    fault_a[F_GEAR] |=> latch_a_ff[F_GEAR]) else $error("A17 not latched");

  a_set_a25: assert property (@(posedge clk) disable iff (srst) // R10
    fault_a[F_MT_ERR] |=> latch_a_ff[F_MT_ERR]) else $error("A25 not latched");

  a_set_a26: assert property (@(posedge clk) disable iff (srst) // R10
    fault_a[F_MT_OVF] |=> latch_a_ff[F_MT_OVF]) else $error("A26 not latched");

  a_set_a27: assert property (@(posedge clk) disable iff (srst) // R11
    fault_a[F_BATT_LOST] |=> latch_a_ff[F_BATT_LOST]) else $error("A27 not latched");

  a_set_a28: assert property (@(posedge clk) disable iff (srst) // R11
    fault_a[F_BATT_LOW] |=> latch_a_ff[F_BATT_LOW]) else $error("A28 not latched");

  a_set_a33: assert property (@(posedge clk) disable iff (srst) // R12
    fault_a[F_OUTAGE] |=> latch_a_ff[F_OUTAGE]) else $error("A33 not latched");

  a_set_a40: assert property (@(posedge clk) disable iff (srst) // R13
    fault_a[F_ENC_COMM] |=> latch_a_ff[F_ENC_COMM]) else $error("A40 not latched");

  a_set_a42: assert property (@(posedge clk) disable iff (srst) // R14
    fault_a[F_ENC_ABS] |=> latch_a_ff[F_ENC_ABS]) else $error("A42 not latched");

  a_set_a43: assert property (@(posedge clk) disable iff (srst) // R14
    fault_a[F_ENC_COUNT] |=> latch_a_ff[F_ENC_COUNT]) else $error("A43 not latched");

  a_set_a44: assert property (@(posedge clk) disable iff (srst) // R15
    fault_a[F_CTRL_CHK] |=> latch_a_ff[F_CTRL_CHK]) else $error("A44 not latched");

  a_set_a45: assert property (@(posedge clk) disable iff (srst) // R15
    fault_a[F_DATA_CHK] |=> latch_a_ff[F_DATA_CHK]) else $error("A45 not latched");

  a_set_a46: assert property (@(posedge clk) disable iff (srst) // R16
    fault_a[F_STAT_STOP] |=> latch_a_ff[F_STAT_STOP]) else $error("A46 not latched");

  a_set_a47: assert property (@(posedge clk) disable iff (srst) // R16
    fault_a[F_MEM_STOP] |=> latch_a_ff[F_MEM_STOP]) else $error("A47 not latched");

  a_set_a48: assert property (@(posedge clk) disable iff (srst) // R17
    fault_a[F_MEM_NULL] |=> latch_a_ff[F_MEM_NULL]) else $error("A48 not latched");

  a_set_a49: assert property (@(posedge clk) disable iff (srst) // R18
    fault_a[F_MEM_SUM] |=> latch_a_ff[F_MEM_SUM]) else $error("A49 not latched");

  a_set_a60: assert property (@(posedge clk) disable iff (srst) // R19
    fault_a[F_MODBUS_TO] |=> latch_a_ff[F_MODBUS_TO]) else $error("A60 not latched");

  a_set_a61: assert property (@(posedge clk) disable iff (srst) // R20
    fault_a[F_HBEAT_TO] |=> latch_a_ff[F_HBEAT_TO]) else $error("A61 not latched");

  // A sample of the same faults on axis B
  a_set_b01: assert property (@(posedge clk) disable iff (srst) // R3
    fault_b[F_PHASE_DISC] |=> latch_b_ff[F_PHASE_DISC]) else $error("b01 not latched");

  a_set_b05: assert property (@(posedge clk) disable iff (srst) // R4
    fault_b[F_COMM_ILLEG] |=> latch_b_ff[F_COMM_ILLEG]) else $error("b05 not latched");

  a_set_b10: assert property (@(posedge clk) disable iff (srst) // R5
    fault_b[F_OVERCURR] |=> latch_b_ff[F_OVERCURR]) else $error("b10 not latched");

  a_set_b13: assert property (@(posedge clk) disable iff (srst) // R7
    fault_b[F_PARAM_BAD] |=> latch_b_ff[F_PARAM_BAD]) else $error("b13 not latched");

  a_set_b27: assert property (@(posedge clk) disable iff (srst) // R11
    fault_b[F_BATT_LOST] |=> latch_b_ff[F_BATT_LOST]) else $error("b27 not latched");

  a_set_b40: assert property (@(posedge clk) disable iff (srst) // R13
    fault_b[F_ENC_COMM] |=> latch_b_ff[F_ENC_COMM]) else $error("b40 not latched");

  a_set_b44: assert property (@(posedge clk) disable iff (srst) // R15
    fault_b[F_CTRL_CHK] |=> latch_b_ff[F_CTRL_CHK]) else $error("b44 not latched");

  a_set_b60: assert property (@(posedge clk) disable iff (srst) // R19
    fault_b[F_MODBUS_TO] |=> latch_b_ff[F_MODBUS_TO]) else $error("b60 not latched");

  // Alarms that no clear request may remove
  a_noclear_a12: assert property (@(posedge clk) disable iff (srst) // R6
    latch_a_ff[F_UNDERVOLT] |=> latch_a_ff[F_UNDERVOLT]) else $error("A12 was cleared");

  a_noclear_a31: assert property (@(posedge clk) disable iff (srst) // R6
    latch_a_ff[F_REGEN] |=> latch_a_ff[F_REGEN]) else $error("A31 was cleared");

  a_noclear_b12: assert property (@(posedge clk) disable iff (srst) // R6
    latch_b_ff[F_UNDERVOLT] |=> latch_b_ff[F_UNDERVOLT]) else $error("b12 was cleared");

  a_noclear_b31: assert property (@(posedge clk) disable iff (srst) // R6
    latch_b_ff[F_REGEN] |=> latch_b_ff[F_REGEN]) else $error("b31 was cleared");

  a_noclear_b90: assert property (@(posedge clk) disable iff (srst) // R6
    latch_b_ff[F_SW_HW] |=> latch_b_ff[F_SW_HW]) else $error("b90 was cleared");

endmodule

// ### sim/sacm_far_side.sv
/*
 * Far-side model for the servo alarm code manager: the motor, encoder and
 * host as seen at the fault inputs and at the alarm clear pin.
 * Assumes the bench states which faults exist; outputs change after clk.
 */
`timescale 1ns/100ps

module sacm_far_side
  import sacm_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Fault conditions requested by the bench
  input  wire logic [NUM_FAULTS-1:0] want_a,
  input  wire logic [NUM_FAULTS-1:0] want_b,
  input  wire logic                  clr_pulse,
  // Levels toward the design
  output logic      [NUM_FAULTS-1:0] fault_a,
  output logic      [NUM_FAULTS-1:0] fault_b,
  output logic                       fault_clear_input_n
);
  logic [2:0] clr_cnt_ff;

  // Frame and heartbeat timeouts appear as fault levels like any other
  always_ff @(posedge clk) begin
    fault_a <= want_a;
    fault_b <= want_b;
  end

  // Host clear pin: held low four cycles so the synchroniser sees it
  always_ff @(posedge clk) begin
    if (srst) begin
      clr_cnt_ff <= 3'h0;
    end else if (clr_pulse) begin
      clr_cnt_ff <= 3'h4;
    end else if (clr_cnt_ff != 3'h0) begin
      clr_cnt_ff <= clr_cnt_ff - 3'h1;
    end
  end
  assign fault_clear_input_n = (clr_cnt_ff == 3'h0);
endmodule

// ### sim/sacm_top_tb.sv
/*
 * Self-checking bench for the servo alarm code manager.
 * Assumes the far-side model in sacm_far_side and the register port map.
 */
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR %0t got %h want %h", $time, (a), (e)); end end

module sacm_top_tb
  import sacm_pkg::*;
;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic [NUM_FAULTS-1:0] want_a = '0;
  logic [NUM_FAULTS-1:0] want_b = '0;
  logic                  clr_pulse = 1'b0;
  logic [NUM_FAULTS-1:0] fault_a;
  logic [NUM_FAULTS-1:0] fault_b;
  logic                  clr_n;
  logic [31:0]           dev_a = '0;
  logic [31:0]           dev_b = '0;
  logic                  pin_assigned = 1'b0;
  logic [ADDR_W-1:0]     reg_addr = '0;
  logic [31:0]           reg_wdata = '0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [31:0]           reg_rdata;
  logic                  fault_output;
  logic                  coast_a;
  logic                  coast_b;
  logic [7:0]            disp_axis;
  logic [7:0]            disp_code;
  int                    err_total = 0;
  int                    checks = 0;

  always #5 clk = ~clk;

  sacm_far_side far (.clk(clk), .srst(srst), .want_a(want_a), .want_b(want_b),
    .clr_pulse(clr_pulse), .fault_a(fault_a), .fault_b(fault_b), .fault_clear_input_n(clr_n));

  sacm_top dut (.clk(clk), .srst(srst), .fault_a(fault_a), .fault_b(fault_b),
    .deviation_a(dev_a), .deviation_b(dev_b), .fault_clear_input_n(clr_n),
    .clear_pin_assigned(pin_assigned), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_output(fault_output),
    .coast_a(coast_a), .coast_b(coast_b), .disp_axis(disp_axis), .disp_code(disp_code));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst   <= 1'b1;
    want_a <= '0;
    want_b <= '0;
    cyc(4);
    srst <= 1'b0;
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic wrap_up();
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #500us;
    err_total++;
    wrap_up();
  end

  initial begin
    do_reset();
    cyc(1);
    `CHK(fault_output, 1'b0)
    reg_read(REG_DEV_LIM, DEV_LIM_RST);
    reg_read(4'hF, 32'h0);
    // Every code on each axis: letter, code, coasting, latch bit, clearability
    for (int ax = 0; ax < 2; ax++) begin
      for (int i = 0; i < NUM_FAULTS; i++) begin
        do_reset();
        if (ax == 0) want_a[i] <= 1'b1;
        else want_b[i] <= 1'b1;
        cyc(3);
        `CHK(disp_axis, (ax == 0) ? AXIS_A_CHAR : AXIS_B_CHAR)
        `CHK(disp_code, ALARM_CODE[i])
        `CHK(fault_output, 1'b1)
        `CHK({coast_a, coast_b}, (ax == 0) ? 2'b10 : 2'b01)
        reg_read(ADDR_W'(REG_LATCH_A0 + 2 * ax + (i / 32)), 32'h1 << (i % 32));
        want_a <= '0;
        want_b <= '0;
        reg_write(REG_CTRL, 32'h4 << ax);
        reg_write(REG_CTRL, 32'h1 << ax);
        cyc(2);
        `CHK(fault_output, NO_CLEAR_MASK[i])
      end
    end
    // Encoder-gated alarm needs the encoder acknowledge first
    do_reset();
    want_a[F_MT_ERR] <= 1'b1;
    cyc(3);
    want_a <= '0;
    reg_write(REG_CTRL, 32'h1);
    cyc(2);
    `CHK(fault_output, 1'b1)
    reg_write(REG_CTRL, 32'h4);
    reg_write(REG_CTRL, 32'h1);
    cyc(2);
    `CHK(fault_output, 1'b0)
    // Clear while the fault persists is refused
    do_reset();
    want_a[F_OVERLOAD] <= 1'b1;
    cyc(3);
    reg_write(REG_CTRL, 32'h1);
    cyc(2);
    `CHK(coast_a, 1'b1)
    want_a <= '0;
    reg_write(REG_CTRL, 32'h1);
    cyc(2);
    `CHK(coast_a, 1'b0)
    // Deviation limit boundary: equal passes, one more trips alarm 16
    do_reset();
    reg_write(REG_DEV_LIM, 32'h0000000A);
    dev_a <= 32'h0000000A;
    cyc(4);
    `CHK(fault_output, 1'b0)
    dev_a <= 32'h0000000B;
    cyc(4);
    `CHK(disp_code, 8'h16)
    dev_a <= '0;
    // First alarm stays shown; both axes coast
    do_reset();
    want_b[F_COMM_ORDER] <= 1'b1;
    cyc(3);
    want_a[F_PHASE_DISC] <= 1'b1;
    cyc(3);
    `CHK({disp_axis, disp_code}, {AXIS_B_CHAR, 8'h06})
    `CHK({coast_a, coast_b}, 2'b11)
    reg_read(REG_STATUS, 32'h00620607);
    // Pin assigned: register clear ignored, pin clear works on both axes
    want_a <= '0;
    want_b <= '0;
    pin_assigned <= 1'b1;
    reg_write(REG_CTRL, 32'h3);
    cyc(2);
    `CHK(fault_output, 1'b1)
    @(posedge clk);
    clr_pulse <= 1'b1;
    @(posedge clk);
    clr_pulse <= 1'b0;
    cyc(10);
    `CHK({fault_output, disp_code}, 9'h000)
    pin_assigned <= 1'b0;
    wrap_up();
  end
endmodule
